// >>> hdl/dma_seq.sv
// DMA channel sequencer: repeat, normal and block modes behind APB
`timescale 1ns/1ps
`default_nettype none
module dma_seq
    import dma_seq_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Activation sources
    input wire logic [3:0] timer_match,
    input wire logic tx_empty,
    input wire logic rx_full,
    input wire logic ext_req_n,
    // System bus
    input wire logic bus_grant,
    input wire logic hp_req,
    input wire logic xfer_done,
    output logic bus_req,
    output logic xfer_valid,
    output logic [23:0] xfer_src,
    output logic [23:0] xfer_dst,
    output logic xfer_word,
    // Completion
    output logic irq
);
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_XFER, S_GAP} state_t;

    trig_if tif ();

    dma_trigger u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .timer_match(timer_match),
        .tx_empty(tx_empty),
        .rx_full(rx_full),
        .ext_req_n(ext_req_n),
        .tif(tif)
    );

    state_t st_r, st_nxt;
    logic [15:0] ctrl_r, ctrl_nxt, rcount_r, rcount_nxt;
    logic [15:0] pcount_r, pcount_nxt, bcount_r, bcount_nxt;
    logic [23:0] mem_addr_r, mem_addr_nxt, src_addr_r, src_addr_nxt;
    logic [23:0] dst_addr_r, dst_addr_nxt, base_r, base_nxt;
    logic [23:0] src_o_r, src_o_nxt, dst_o_r, dst_o_nxt, delta, stepped;
    logic [7:0] periph_low_r, periph_low_nxt, live;
    logic done_r, done_nxt, irq_r, irq_nxt, inblk_r, inblk_nxt;
    logic bus_req_r, bus_req_nxt, valid_r, valid_nxt, word_r, word_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic en, sz, fin, keep, wr, hit;
    logic [1:0] mode;
    logic [23:0] periph;

    function automatic logic [23:0] step(input logic [23:0] a,
                                         input logic [1:0] f,
                                         input logic s);
        logic [23:0] n;
        n = s ? 24'h000002 : 24'h000001;
        if (!f[0])
            step = a;
        else if (f[1])
            step = a - n;
        else
            step = a + n;
    endfunction

    assign en = ctrl_r[CHANNEL_ENABLE_BIT];
    assign sz = ctrl_r[TRANSFER_SIZE_BIT];
    assign mode = ctrl_r[MODE_LSB +: 2];
    assign periph = {PERIPH_HIGH, periph_low_r};
    assign tif.en = en;
    assign tif.level = ctrl_r[LEVEL_SENSE_BIT];
    assign tif.mode = mode;
    assign tif.sel = ctrl_r[TRIG_SEL_LSB +: 3];
    assign wr = psel && penable && pready_r && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    always_comb
    begin
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        hit = 1'b1;
        unique case (paddr)
            OFF_CONTROL: prdata_nxt = {16'h0000, ctrl_r};
            OFF_MEMORY_ADDRESS: prdata_nxt = {8'h00, mem_addr_r};
            OFF_PERIPH_LOW: prdata_nxt = {24'h000000, periph_low_r};
            OFF_TRANSFER_COUNT: prdata_nxt = {16'h0000, rcount_r};
            OFF_SOURCE_ADDRESS: prdata_nxt = {8'h00, src_addr_r};
            OFF_DEST_ADDRESS: prdata_nxt = {8'h00, dst_addr_r};
            OFF_PAIRED_COUNT: prdata_nxt = {16'h0000, pcount_r};
            OFF_BLOCK_COUNT: prdata_nxt = {16'h0000, bcount_r};
            OFF_STATUS: prdata_nxt = {29'h0, st_r != S_IDLE, inblk_r, done_r};
            default:
            begin
                prdata_nxt = 32'h00000000;
                hit = 1'b0;
            end
        endcase
        if (!pready_nxt)
            prdata_nxt = prdata_r;
        else
            pslverr_nxt = !hit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb
    begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        rcount_nxt = rcount_r;
        pcount_nxt = pcount_r;
        bcount_nxt = bcount_r;
        mem_addr_nxt = mem_addr_r;
        src_addr_nxt = src_addr_r;
        dst_addr_nxt = dst_addr_r;
        periph_low_nxt = periph_low_r;
        base_nxt = base_r;
        inblk_nxt = inblk_r;
        bus_req_nxt = bus_req_r;
        valid_nxt = valid_r;
        word_nxt = word_r;
        src_o_nxt = src_o_r;
        dst_o_nxt = dst_o_r;
        tif.ack = 1'b0;
        fin = 1'b0;
        keep = 1'b0;
        live = 8'h00;
        delta = 24'h000000;
        stepped = 24'h000000;
        unique case (st_r)
            S_IDLE:
                if (en && (tif.pending || inblk_r))
                begin
                    st_nxt = S_REQ;
                    bus_req_nxt = 1'b1;
                end
            S_REQ:
                if (!en)
                begin
                    // Request stays pending for the resume
                    st_nxt = S_GAP;
                    bus_req_nxt = 1'b0;
                end
                else if (bus_grant)
                begin
                    st_nxt = S_XFER;
                    valid_nxt = 1'b1;
                    word_nxt = sz;
                    tif.ack = !inblk_r;
                    if (mode == M_REPEAT && tif.rx)
                    begin
                        src_o_nxt = periph;
                        dst_o_nxt = mem_addr_r;
                    end
                    else if (mode == M_REPEAT)
                    begin
                        src_o_nxt = mem_addr_r;
                        dst_o_nxt = periph;
                    end
                    else
                    begin
                        src_o_nxt = src_addr_r;
                        dst_o_nxt = dst_addr_r;
                    end
                    if (mode == M_BLOCK && !inblk_r)
                    begin
                        inblk_nxt = 1'b1;
                        base_nxt = ctrl_r[BLOCK_AREA_SEL] ? src_addr_r
                            : dst_addr_r;
                    end
                end
            S_XFER:
                if (xfer_done)
                begin
                    valid_nxt = 1'b0;
                    if (mode == M_REPEAT)
                    begin
                        stepped = step(mem_addr_r,
                            {ctrl_r[ADDRESS_DIRECTION_BIT], 1'b1}, sz);
                        live = rcount_r[15:8] - 8'h01;
                        mem_addr_nxt = stepped;
                        rcount_nxt[15:8] = live;
                        if (live == 8'h00)
                        begin
                            rcount_nxt[15:8] = rcount_r[7:0];
                            delta = {16'h0000, rcount_r[7:0]} << sz;
                            mem_addr_nxt = ctrl_r[ADDRESS_DIRECTION_BIT]
                                ? stepped + delta : stepped - delta;
                        end
                    end
                    else
                    begin
                        src_addr_nxt = step(src_addr_r,
                            ctrl_r[SRC_STEP_LSB +: 2], sz);
                        dst_addr_nxt = step(dst_addr_r,
                            ctrl_r[DST_STEP_LSB +: 2], sz);
                    end
                    if (mode == M_NORMAL)
                    begin
                        pcount_nxt = pcount_r - 16'h0001;
                        fin = (pcount_r == 16'h0001);
                        keep = ctrl_r[BURST_BIT]
                            && tif.sel == T_AUTO;
                    end
                    if (mode == M_BLOCK)
                    begin
                        live = pcount_r[15:8] - 8'h01;
                        pcount_nxt[15:8] = live;
                        keep = 1'b1;
                        if (live == 8'h00)
                        begin
                            pcount_nxt[15:8] = pcount_r[7:0];
                            if (ctrl_r[BLOCK_AREA_SEL])
                                src_addr_nxt = base_r;
                            else
                                dst_addr_nxt = base_r;
                            bcount_nxt = bcount_r - 16'h0001;
                            fin = (bcount_r == 16'h0001);
                            inblk_nxt = 1'b0;
                            keep = 1'b0;
                        end
                    end
                    if (fin)
                        ctrl_nxt[CHANNEL_ENABLE_BIT] = 1'b0;
                    // A higher master always gets the bus back
                    if (fin || !keep || hp_req)
                    begin
                        st_nxt = S_GAP;
                        bus_req_nxt = 1'b0;
                    end
                    else
                        st_nxt = S_REQ;
                end
            S_GAP:
                st_nxt = S_IDLE;
        endcase
        if (wr)
        begin
            unique case (paddr)
                OFF_CONTROL: ctrl_nxt = pwdata[15:0];
                OFF_MEMORY_ADDRESS: mem_addr_nxt = pwdata[23:0];
                OFF_PERIPH_LOW: periph_low_nxt = pwdata[7:0];
                OFF_TRANSFER_COUNT: rcount_nxt = pwdata[15:0];
                OFF_SOURCE_ADDRESS: src_addr_nxt = pwdata[23:0];
                OFF_DEST_ADDRESS: dst_addr_nxt = pwdata[23:0];
                OFF_PAIRED_COUNT: pcount_nxt = pwdata[15:0];
                OFF_BLOCK_COUNT: bcount_nxt = pwdata[15:0];
                default: ;
            endcase
        end
        // Completion set wins over a clear in the same cycle
        done_nxt = (done_r && !(wr && paddr == OFF_STATUS && pwdata[0]))
            || fin;
        irq_nxt = done_nxt && ctrl_nxt[COMPLETION_IRQ_ENABLE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= S_IDLE;
            ctrl_r <= CONTROL_RESET;
            rcount_r <= 16'h0000;
            pcount_r <= 16'h0000;
            bcount_r <= 16'h0000;
            mem_addr_r <= 24'h000000;
            src_addr_r <= 24'h000000;
            dst_addr_r <= 24'h000000;
            periph_low_r <= 8'h00;
            base_r <= 24'h000000;
            src_o_r <= 24'h000000;
            dst_o_r <= 24'h000000;
            inblk_r <= 1'b0;
            bus_req_r <= 1'b0;
            valid_r <= 1'b0;
            word_r <= 1'b0;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            rcount_r <= rcount_nxt;
            pcount_r <= pcount_nxt;
            bcount_r <= bcount_nxt;
            mem_addr_r <= mem_addr_nxt;
            src_addr_r <= src_addr_nxt;
            dst_addr_r <= dst_addr_nxt;
            periph_low_r <= periph_low_nxt;
            base_r <= base_nxt;
            src_o_r <= src_o_nxt;
            dst_o_r <= dst_o_nxt;
            inblk_r <= inblk_nxt;
            bus_req_r <= bus_req_nxt;
            valid_r <= valid_nxt;
            word_r <= word_nxt;
            done_r <= done_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bus_req = bus_req_r;
    assign xfer_valid = valid_r;
    assign xfer_src = src_o_r;
    assign xfer_dst = dst_o_r;
    assign xfer_word = word_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic xd;
    assign xd = st_r == S_XFER && xfer_done && !wr;

    a_repeat_reload: assert property (
        xd && mode == M_REPEAT && rcount_r[15:8] == 8'h01
        |=> rcount_r[15:8] == $past(rcount_r[7:0]))
        else $error("repeat count not reloaded");
    a_repeat_quiet: assert property (
        xd && mode == M_REPEAT |=> !$rose(done_r) && en)
        else $error("repeat mode ended or flagged completion");
    a_periph_high: assert property (
        valid_r && mode == M_REPEAT |-> xfer_src[23:8] == PERIPH_HIGH
        || xfer_dst[23:8] == PERIPH_HIGH)
        else $error("peripheral high bits wrong");
    a_normal_end: assert property (
        xd && mode == M_NORMAL && pcount_r == 16'h0001
        |=> !en && done_r && (irq_r == ctrl_r[COMPLETION_IRQ_ENABLE]))
        else $error("normal mode did not finish");
    a_steal_release: assert property (
        xd && mode == M_NORMAL && !ctrl_r[BURST_BIT] |=> !bus_req_r ##1
        !bus_req_r)
        else $error("cycle steal kept the bus");
    a_burst_hold: assert property (
        xd && mode == M_NORMAL && ctrl_r[BURST_BIT] && tif.sel == T_AUTO
        && pcount_r != 16'h0001 && !hp_req |=> bus_req_r[*2])
        else $error("burst released the bus");
    a_block_reload: assert property (
        xd && mode == M_BLOCK && pcount_r[15:8] == 8'h01
        |=> pcount_r[15:8] == $past(pcount_r[7:0])
        && bcount_r == $past(bcount_r) - 16'h0001)
        else $error("block size not reloaded");
    a_block_area: assert property (
        xd && mode == M_BLOCK && !ctrl_r[BLOCK_AREA_SEL]
        && pcount_r[15:8] == 8'h01 |=> dst_addr_r == $past(base_r))
        else $error("block area not restored");
    a_block_wait: assert property (
        xd && mode == M_BLOCK && pcount_r[15:8] == 8'h01
        |=> !inblk_r && !bus_req_r ##1 st_r == S_IDLE)
        else $error("block end did not release");

    c_repeat_wrap: cover property (
        xd && mode == M_REPEAT && rcount_r[15:8] == 8'h01);
    c_normal_done: cover property (xd && mode == M_NORMAL ##1 done_r);
    c_burst_keep: cover property (xd && mode == M_NORMAL ##1 st_r == S_REQ);
    c_block_end: cover property (xd && mode == M_BLOCK ##1 !inblk_r);
endmodule
`default_nettype wire

// >>> common/dma_seq_pkg.sv
// Constants for the DMA address and count sequencer
package dma_seq_pkg;
    // Register byte addresses
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_MEMORY_ADDRESS = 8'h04;
    localparam logic [7:0] OFF_PERIPH_LOW = 8'h08;
    localparam logic [7:0] OFF_TRANSFER_COUNT = 8'h0c;
    localparam logic [7:0] OFF_SOURCE_ADDRESS = 8'h10;
    localparam logic [7:0] OFF_DEST_ADDRESS = 8'h14;
    localparam logic [7:0] OFF_PAIRED_COUNT = 8'h18;
    localparam logic [7:0] OFF_BLOCK_COUNT = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Control field positions
    localparam int CHANNEL_ENABLE_BIT = 0;
    localparam int COMPLETION_IRQ_ENABLE = 1;
    localparam int TRANSFER_SIZE_BIT = 2;
    localparam int ADDRESS_DIRECTION_BIT = 3;
    localparam int MODE_LSB = 4;
    localparam int BLOCK_AREA_SEL = 6;
    localparam int BURST_BIT = 7;
    localparam int TRIG_SEL_LSB = 8;
    localparam int LEVEL_SENSE_BIT = 11;
    localparam int SRC_STEP_LSB = 12;
    localparam int DST_STEP_LSB = 14;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    // Modes and trigger selects
    localparam logic [1:0] M_REPEAT = 2'h0;
    localparam logic [1:0] M_NORMAL = 2'h1;
    localparam logic [1:0] M_BLOCK = 2'h2;
    localparam logic [2:0] T_LAST_TIMER = 3'h3;
    localparam logic [2:0] T_TX_EMPTY = 3'h4;
    localparam logic [2:0] T_RX_FULL = 3'h5;
    localparam logic [2:0] T_EXTERNAL = 3'h6;
    localparam logic [2:0] T_AUTO = 3'h7;
    localparam logic [15:0] PERIPH_HIGH = 16'hffff;
endpackage

// >>> common/trig_if.sv
// Carrier between the sequencer and its activation source logic
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
    logic pending;
    logic rx;
    logic ack;
    logic en;
    logic level;
    logic [1:0] mode;
    logic [2:0] sel;
    modport seq (input pending, rx, output ack, en, level, mode, sel);
    modport src (output pending, rx, input ack, en, level, mode, sel);
endinterface
`default_nettype wire

// >>> hdl/dma_trigger.sv
// Activation source selection and pending request latch
`timescale 1ns/1ps
`default_nettype none
module dma_trigger
    import dma_seq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request sources
    input wire logic [3:0] timer_match,
    input wire logic tx_empty,
    input wire logic rx_full,
    input wire logic ext_req_n,
    // Sequencer side
    trig_if.src tif
);
    logic pend_r, pend_nxt, rx_r, rx_nxt, ext_q_r, ext_q_nxt;
    logic hit, allowed, auto_on;

    function automatic logic legal(input logic [1:0] m, input logic [2:0] s);
        case (m)
            M_NORMAL: legal = (s == T_EXTERNAL) || (s == T_AUTO);
            M_BLOCK: legal = (s <= T_LAST_TIMER) || (s == T_EXTERNAL);
            default: legal = (s != T_AUTO);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ext_q_nxt = ext_req_n;
        allowed = legal(tif.mode, tif.sel);
        auto_on = tif.en && allowed && (tif.sel == T_AUTO);
        // Block mode only knows the falling edge
        if (tif.sel <= T_LAST_TIMER)
            hit = timer_match[tif.sel[1:0]];
        else if (tif.sel == T_TX_EMPTY)
            hit = tx_empty;
        else if (tif.sel == T_RX_FULL)
            hit = rx_full;
        else if (tif.sel == T_EXTERNAL)
            hit = (tif.level && tif.mode != M_BLOCK) ? !ext_req_n
                : (ext_q_r && !ext_req_n);
        else
            hit = 1'b0;
        pend_nxt = pend_r;
        rx_nxt = rx_r;
        if (tif.ack)
            pend_nxt = 1'b0;
        // A new event in the ack cycle is kept
        if (tif.en && allowed && hit)
        begin
            pend_nxt = 1'b1;
            rx_nxt = (tif.sel == T_RX_FULL);
        end
        tif.pending = pend_r || auto_on;
        tif.rx = rx_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_r <= 1'b0;
            rx_r <= 1'b0;
            ext_q_r <= 1'b1;
        end
        else
        begin
            pend_r <= pend_nxt;
            rx_r <= rx_nxt;
            ext_q_r <= ext_q_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> dv/sys_bus_model.sv
// System bus partner: grants the bus and completes each transfer
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sequencer side
    input wire logic bus_req,
    input wire logic xfer_valid,
    input wire logic slow,
    output logic bus_grant,
    output logic xfer_done,
    output logic hp_req
);
    logic [1:0] wait_r;
    // Slow mode stretches each transfer and lets a higher master ask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_grant <= 1'b0;
            xfer_done <= 1'b0;
            hp_req <= 1'b0;
            wait_r <= 2'h0;
        end
        else
        begin
            bus_grant <= bus_req;
            hp_req <= slow;
            xfer_done <= 1'b0;
            if (xfer_valid && !xfer_done)
            begin
                wait_r <= wait_r + 2'h1;
                if (wait_r >= {slow, 1'b0})
                begin
                    xfer_done <= 1'b1;
                    wait_r <= 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Testbench for the DMA sequencer with scoreboards of transfers and reads
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dma_seq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic tx_empty, rx_full, ext_req_n, bus_grant, hp_req, xfer_done;
    logic bus_req, xfer_valid, xfer_word, irq;
    logic [7:0] paddr, plow;
    logic [31:0] pwdata, prdata;
    logic [3:0] timer_match;
    logic [23:0] xfer_src, xfer_dst, base, pa;
    logic [63:0] rq[$], xq[$];
    int fail_count, tests_run;
    dma_seq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_match(timer_match), .tx_empty(tx_empty), .rx_full(rx_full),
        .ext_req_n(ext_req_n), .bus_grant(bus_grant), .hp_req(hp_req),
        .xfer_done(xfer_done), .bus_req(bus_req), .xfer_valid(xfer_valid),
        .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word),
        .irq(irq));
    sys_bus_model u_bus (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
        .xfer_valid(xfer_valid), .slow(slow), .bus_grant(bus_grant),
        .xfer_done(xfer_done), .hp_req(hp_req));
    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic [63:0] got, input logic [63:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task cmp_read(input logic [63:0] g, input logic [63:0] e);
        cmp(g, e, "read");
    endtask
    task cmp_xfer(input logic [63:0] g, input logic [63:0] e);
        cmp(g, e, "xfer");
    endtask
    // Bus request rides along: a finished or idle channel holds no bus
    task cmp_irq(input logic [63:0] g, input logic [63:0] e);
        cmp(g, e, "irq and bus request");
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [63:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task ex(input logic w, input logic [23:0] s, input logic [23:0] d);
        xq.push_back({15'h0, w, s, d});
    endtask
    // One request pulse on the source picked by i, matching trigger select
    task trig(input int i);
        @(posedge pclk);
        timer_match <= (i < 4) ? 4'h1 << i : 4'h0;
        tx_empty <= (i == 4);
        rx_full <= (i == 5);
        ext_req_n <= (i != 6);
        @(posedge pclk);
        timer_match <= 4'h0;
        tx_empty <= 1'b0;
        rx_full <= 1'b0;
        ext_req_n <= 1'b1;
    endtask
    task wait_x(input int n);
        int j;
        repeat (n)
        begin
            j = 0;
            do begin @(posedge pclk); j++; end
            while (!(xfer_valid === 1'b1 && xfer_done === 1'b1) && j < 200);
            if (j >= 200) cmp(64'h0, 64'h1, "transfer timeout");
        end
        repeat (10) @(posedge pclk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scoreboard: an empty queue yields X, so any extra result mismatches
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_read({31'h0, pslverr, prdata},
                rq.size() > 0 ? rq.pop_front() : 64'hx);
        if (xfer_valid === 1'b1 && xfer_done === 1'b1)
            cmp_xfer({15'h0, xfer_word, xfer_src, xfer_dst},
                xq.size() > 0 ? xq.pop_front() : 64'hx);
    end
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #500us;
        fail_count++;
        complete_run();
    end
    initial
    begin
        int i;
        {psel, penable, pwrite, tx_empty, rx_full, slow} = 6'h0;
        {paddr, pwdata, timer_match} = 44'h0;
        ext_req_n = 1'b1;
        presetn = 1'b0;
        void'($urandom(32'he957));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CONTROL, 64'h0);
        rd(OFF_STATUS, 64'h0);
        rd(8'h24, 64'h1_0000_0000);
        base = {12'h0, 12'($urandom) & 12'hffe};
        plow = 8'($urandom);
        pa = {PERIPH_HIGH, plow};
        apb(1'b1, OFF_MEMORY_ADDRESS, {8'h0, base});
        apb(1'b1, OFF_PERIPH_LOW, {24'h0, plow});
        apb(1'b1, OFF_TRANSFER_COUNT, 32'h0202);
        for (i = 0; i < 7; i++)
        begin
            apb(1'b1, OFF_CONTROL, 32'h1 | (32'(i) << 8));
            if (i == 5) ex(1'b0, pa, base + 24'(i % 2));
            else ex(1'b0, base + 24'(i % 2), pa);
            trig(i);
            wait_x(1);
        end
        rd(OFF_TRANSFER_COUNT, 64'h0102);
        rd(OFF_PERIPH_LOW, {56'h0, plow});
        cmp_irq({62'h0, bus_req, irq}, 64'h0);
        apb(1'b1, OFF_CONTROL, 32'h0);
        trig(0);
        repeat (10) @(posedge pclk);
        ex(1'b0, base + 24'h1, pa);
        apb(1'b1, OFF_CONTROL, 32'h1);
        trig(0);
        wait_x(1);
        // Word units, decrementing, one-transfer cycle: each wrap lands on base
        apb(1'b1, OFF_TRANSFER_COUNT, 32'h0101);
        apb(1'b1, OFF_CONTROL, 32'hd);
        repeat (2)
        begin
            ex(1'b1, base, pa);
            trig(0);
            wait_x(1);
        end
        apb(1'b1, OFF_TRANSFER_COUNT, 32'hffff);
        rd(OFF_TRANSFER_COUNT, 64'hffff);
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, OFF_SOURCE_ADDRESS, 32'h200);
            apb(1'b1, OFF_DEST_ADDRESS, 32'h300);
            apb(1'b1, OFF_PAIRED_COUNT, 32'h2);
            ex(1'b1, 24'h200, 24'h300);
            ex(1'b1, 24'h202, 24'h2fe);
            slow <= 1'($urandom);
            apb(1'b1, OFF_CONTROL, 32'hd717 | (32'(i) << 7));
            wait_x(2);
            rd(OFF_CONTROL, 64'hd716 | (64'(i) << 7));
            cmp_irq({62'h0, bus_req, irq}, 64'h1);
            apb(1'b1, OFF_STATUS, 32'h1);
            rd(OFF_STATUS, 64'h0);
            cmp_irq({62'h0, bus_req, irq}, 64'h0);
        end
        apb(1'b1, OFF_SOURCE_ADDRESS, 32'h400);
        apb(1'b1, OFF_DEST_ADDRESS, 32'h500);
        apb(1'b1, OFF_PAIRED_COUNT, 32'h0202);
        apb(1'b1, OFF_BLOCK_COUNT, 32'h2);
        apb(1'b1, OFF_CONTROL, 32'h5623);
        for (i = 0; i < 2; i++)
        begin
            ex(1'b0, 24'h400 + 24'(2 * i), 24'h500);
            ex(1'b0, 24'h401 + 24'(2 * i), 24'h501);
            trig(6);
            wait_x(2);
        end
        rd(OFF_CONTROL, 64'h5622);
        cmp_irq({62'h0, bus_req, irq}, 64'h1);
        rd(OFF_PAIRED_COUNT, 64'h0202);
        apb(1'b1, OFF_CONTROL, 32'h5421);
        trig(4);
        repeat (10) @(posedge pclk);
        apb(1'b1, OFF_CONTROL, 32'h0);
        repeat (20) @(posedge pclk);
        complete_run();
    end
endmodule
`default_nettype wire
